// [gpio_output_watchdog_config.sv]
// Pin configuration, strap override and control channel watchdog register group.
// Assumes register accesses arrive as one-cycle strobes from the serial control bus slave.
`timescale 1ns/1ps
module gpio_output_watchdog_config #(
	parameter int WDT_UNIT_CYCLES = gpio_wdt_pkg::WDT_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// Register access from the serial control bus
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// General purpose pins
	input  wire logic [3:0] pin_in,
	output logic      [3:0] pin_out,
	output logic      [3:0] pin_oe,
	// Strapped selections and their effective values
	input  wire logic       strap_output_gate_select,
	input  wire logic       strap_output_sleep_state_select,
	output logic            output_gate_select,
	output logic            output_sleep_state_select,
	// Bidirectional control channel transactions
	input  wire logic       bidir_control_channel_start,
	input  wire logic       bidir_control_channel_done,
	output logic            bidir_control_channel_abort,
	output logic            bidir_control_channel_busy
);
	import gpio_wdt_pkg::*;

	logic [7:0] pin23_cfg_q;
	logic [7:0] pin01_cfg_q;
	logic       strap_override_q;
	logic       gate_sel_q;
	logic       sleep_sel_q;
	logic       strap_caught_q;
	logic [6:0] wdt_timeout_q;
	logic       wdt_disable_q;
	logic [7:0] rdata_q;
	logic       rvalid_q;
	logic       gate_q;
	logic       sleep_q;
	logic [3:0] pin_en;
	logic [3:0] pin_dir;
	logic [3:0] pin_val;

	wdt_if wd_bus ();

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target);
		return reg_wr && (addr == target);
	endfunction

	// ----------------------------------------------------------------
	// Pin configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pin23_cfg_q <= PIN_CFG_RESET;
		end else if (wr_hit(reg_addr, PIN23_CFG_ADDR)) begin
			pin23_cfg_q <= reg_wdata & PIN_CFG_WMASK;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pin01_cfg_q <= PIN_CFG_RESET;
		end else if (wr_hit(reg_addr, PIN01_CFG_ADDR)) begin
			pin01_cfg_q <= reg_wdata & PIN_CFG_WMASK;
		end
	end

	// Pins 0/1 live in the 0x1E byte, pins 2/3 in the 0x1D byte
	assign pin_val = {pin23_cfg_q[LO_VALUE_BIT], pin23_cfg_q[HI_VALUE_BIT],
	                  pin01_cfg_q[LO_VALUE_BIT], pin01_cfg_q[HI_VALUE_BIT]};
	assign pin_dir = {pin23_cfg_q[LO_DIR_BIT], pin23_cfg_q[HI_DIR_BIT],
	                  pin01_cfg_q[LO_DIR_BIT], pin01_cfg_q[HI_DIR_BIT]};
	assign pin_en  = {pin23_cfg_q[LO_EN_BIT], pin23_cfg_q[HI_EN_BIT],
	                  pin01_cfg_q[LO_EN_BIT], pin01_cfg_q[HI_EN_BIT]};

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	assign pin_oe  = pin_en & ~pin_dir;
	assign pin_out = pin_val & pin_oe;

	// ----------------------------------------------------------------
	// Strap override register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_override_q <= STRAP_OVR_RESET[OVR_BIT];
			gate_sel_q       <= STRAP_OVR_RESET[GATE_SEL_BIT];
		end else if (wr_hit(reg_addr, STRAP_OVR_ADDR)) begin
			strap_override_q <= reg_wdata[OVR_BIT];
			gate_sel_q       <= reg_wdata[GATE_SEL_BIT];
		end
	end

	// Read-only sleep copy: strapped level caught once after reset release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_caught_q <= 1'b0;
			sleep_sel_q    <= STRAP_OVR_RESET[SLEEP_SEL_BIT];
		end else if (!strap_caught_q) begin
			strap_caught_q <= 1'b1;
			sleep_sel_q    <= strap_output_sleep_state_select;
		end
	end

	// ----------------------------------------------------------------
	// Effective gate and sleep selections
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gate_q  <= 1'b0;
			sleep_q <= 1'b0;
		end else if (strap_override_q) begin
			gate_q  <= gate_sel_q;
			sleep_q <= sleep_sel_q;
		end else begin
			gate_q  <= strap_output_gate_select;
			sleep_q <= strap_output_sleep_state_select;
		end
	end

	assign output_gate_select        = gate_q;
	assign output_sleep_state_select = sleep_q;

	// ----------------------------------------------------------------
	// Watchdog control register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wdt_timeout_q <= WDT_CTRL_RESET[7:1];
			wdt_disable_q <= WDT_CTRL_RESET[WDT_DISABLE_BIT];
		end else if (wr_hit(reg_addr, WDT_CTRL_ADDR)) begin
			wdt_timeout_q <= reg_wdata[7:1];
			wdt_disable_q <= reg_wdata[WDT_DISABLE_BIT];
		end
	end

	assign wd_bus.timeout_units = wdt_timeout_q;
	assign wd_bus.wdt_disable   = wdt_disable_q;
	assign wd_bus.txn_start     = bidir_control_channel_start;
	assign wd_bus.txn_done      = bidir_control_channel_done;

	chan_watchdog #(
		.UNIT_CYCLES (WDT_UNIT_CYCLES)
	) u_watchdog (
		.mclk   (mclk),
		.resetn (resetn),
		.wd     (wd_bus.wdt)
	);

	assign bidir_control_channel_abort = wd_bus.txn_abort;
	assign bidir_control_channel_busy  = wd_bus.txn_busy;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					PIN23_CFG_ADDR: rdata_q <= pin23_cfg_q;
					PIN01_CFG_ADDR: rdata_q <= pin01_cfg_q;
					STRAP_OVR_ADDR: rdata_q <= {strap_override_q, gate_sel_q,
					                            sleep_sel_q, 5'h00};
					WDT_CTRL_ADDR:  rdata_q <= {wdt_timeout_q, wdt_disable_q};
					default:        rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_PIN_DISABLED_FLOATS: assert property (@(posedge mclk) disable iff (!resetn)
		(wr_hit(reg_addr, PIN01_CFG_ADDR) && !reg_wdata[HI_EN_BIT]) |=> !pin_oe[0])
		else $error("Disabled pin 0 still driven");
	AST_PIN_INPUT_FLOATS: assert property (@(posedge mclk) disable iff (!resetn)
		(wr_hit(reg_addr, PIN23_CFG_ADDR) && reg_wdata[HI_DIR_BIT]) |=> !pin_oe[2])
		else $error("Pin 2 set as input still driven");
	AST_PIN_DRIVES_VALUE: assert property (@(posedge mclk) disable iff (!resetn)
		(wr_hit(reg_addr, PIN23_CFG_ADDR) && reg_wdata[LO_EN_BIT] && !reg_wdata[LO_DIR_BIT])
		|=> (pin_oe[3] && pin_out[3] == $past(reg_wdata[LO_VALUE_BIT])))
		else $error("Enabled output pin 3 not driving its value");
	AST_PIN_CFG_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
		wr_hit(reg_addr, PIN01_CFG_ADDR) |=> pin01_cfg_q == ($past(reg_wdata) & 8'hBB))
		else $error("Pin 0/1 config not stored with reserved bits clear");
	AST_OVERRIDE_GATE: assert property (@(posedge mclk) disable iff (!resetn)
		strap_override_q |=> output_gate_select == $past(gate_sel_q))
		else $error("Override active but gate select not from register");
	AST_OVERRIDE_SLEEP: assert property (@(posedge mclk) disable iff (!resetn)
		strap_override_q |=> output_sleep_state_select == $past(sleep_sel_q))
		else $error("Override active but sleep select not from register");
	AST_NO_OVERRIDE_STRAP: assert property (@(posedge mclk) disable iff (!resetn)
		!strap_override_q |=> (output_gate_select == $past(strap_output_gate_select) &&
			output_sleep_state_select == $past(strap_output_sleep_state_select)))
		else $error("Strapped selections not followed without override");
	AST_SLEEP_READ_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
		(strap_caught_q && wr_hit(reg_addr, STRAP_OVR_ADDR)) |=> $stable(sleep_sel_q))
		else $error("Read-only sleep select changed by a write");
	AST_WDT_TIMEOUT_FIELD: assert property (@(posedge mclk) disable iff (!resetn)
		wr_hit(reg_addr, WDT_CTRL_ADDR) |=> (wd_bus.timeout_units == $past(reg_wdata[7:1]) &&
			wd_bus.wdt_disable == $past(reg_wdata[0])))
		else $error("Watchdog control write not applied");
	AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (!resetn)
		(reg_rd && reg_addr == WDT_CTRL_ADDR && !reg_wr) |=>
			(reg_rvalid && reg_rdata == {wdt_timeout_q, wdt_disable_q}))
		else $error("Watchdog control readback wrong");
endmodule

// [gpio_wdt_pkg.sv]
// Constants for the pin, strap override and control channel watchdog register group.
// Assumes a single 40 MHz clock and an 8-bit register access port.
package gpio_wdt_pkg;
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN23_CFG_ADDR   = 8'h1D;
	localparam logic [7:0] PIN01_CFG_ADDR   = 8'h1E;
	localparam logic [7:0] STRAP_OVR_ADDR   = 8'h1F;
	localparam logic [7:0] WDT_CTRL_ADDR    = 8'h20;
	localparam logic [7:0] PIN_CFG_RESET    = 8'h33;
	localparam logic [7:0] STRAP_OVR_RESET  = 8'h00;
	localparam logic [7:0] WDT_CTRL_RESET   = 8'hFE;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN_CFG_WMASK    = 8'hBB;
	localparam int         HI_VALUE_BIT     = 7;
	localparam int         HI_DIR_BIT       = 5;
	localparam int         HI_EN_BIT        = 4;
	localparam int         LO_VALUE_BIT     = 3;
	localparam int         LO_DIR_BIT       = 1;
	localparam int         LO_EN_BIT        = 0;
	localparam int         OVR_BIT          = 7;
	localparam int         GATE_SEL_BIT     = 6;
	localparam int         SLEEP_SEL_BIT    = 5;
	localparam int         WDT_DISABLE_BIT  = 0;
	localparam int         WDT_TIMEOUT_W    = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_HZ           = 40000000;
	localparam int         WDT_UNIT_MS      = 2;
	localparam int         WDT_UNIT_CYCLES  = CLK_HZ / 1000 * WDT_UNIT_MS;
	localparam int         WDT_PRE_W        = 24;

	// ----------------------------------------------------------------
	// Watchdog states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WD_IDLE = 2'b01,
		WD_BUSY = 2'b10
	} wd_state_t;
endpackage

// [wdt_if.sv]
// Carrier between the register group and its control channel watchdog.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface wdt_if;
	import gpio_wdt_pkg::*;
	logic [WDT_TIMEOUT_W-1:0] timeout_units;
	logic                     wdt_disable;
	logic                     txn_start;
	logic                     txn_done;
	logic                     txn_abort;
	logic                     txn_busy;

	modport cfg (
		output timeout_units,
		output wdt_disable,
		output txn_start,
		output txn_done,
		input  txn_abort,
		input  txn_busy
	);
	modport wdt (
		input  timeout_units,
		input  wdt_disable,
		input  txn_start,
		input  txn_done,
		output txn_abort,
		output txn_busy
	);
endinterface

// [chan_watchdog.sv]
// Control channel transaction watchdog.
// Assumes start and done are one-cycle pulses in the mclk domain.
`timescale 1ns/1ps
module chan_watchdog #(
	parameter int UNIT_CYCLES = gpio_wdt_pkg::WDT_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// Configuration and transaction events
	wdt_if.wdt        wd
);
	import gpio_wdt_pkg::*;

	localparam logic [WDT_PRE_W-1:0] PRE_LAST = WDT_PRE_W'(UNIT_CYCLES - 1);

	wd_state_t                state_q;
	logic [WDT_PRE_W-1:0]     pre_q;
	logic [WDT_TIMEOUT_W-1:0] unit_q;
	logic                     abort_q;
	logic                     tick;
	logic                     expire;

	// ----------------------------------------------------------------
	// Timeout detection
	// ----------------------------------------------------------------
	assign tick   = (state_q == WD_BUSY) && !wd.wdt_disable && (pre_q == PRE_LAST);
	assign expire = tick && ({1'b0, unit_q} + 8'h01 >= {1'b0, wd.timeout_units});

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= WD_IDLE;
		end else if (wd.txn_start) begin
			state_q <= WD_BUSY;
		end else begin
			unique case (state_q)
				WD_IDLE: state_q <= WD_IDLE;
				WD_BUSY: begin
					if (wd.txn_done || expire) begin
						state_q <= WD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pre_q  <= '0;
			unit_q <= '0;
		end else if (wd.txn_start || state_q != WD_BUSY || wd.wdt_disable) begin
			pre_q  <= '0;
			unit_q <= '0;
		end else if (tick) begin
			pre_q  <= '0;
			unit_q <= unit_q + 7'h01;
		end else begin
			pre_q  <= pre_q + 24'h000001;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= expire && !wd.txn_start && !wd.txn_done;
		end
	end

	assign wd.txn_abort = abort_q;
	assign wd.txn_busy  = (state_q == WD_BUSY);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_WDT_ABORT_ONLY_ENABLED: assert property (@(posedge mclk) disable iff (!resetn)
		wd.txn_abort |-> $past(!wd.wdt_disable && state_q == WD_BUSY))
		else $error("Watchdog aborted while disabled or idle");
	AST_WDT_ABORT_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
		wd.txn_abort |-> !wd.txn_busy)
		else $error("Channel not idle after watchdog abort");
	AST_WDT_RESTART: assert property (@(posedge mclk) disable iff (!resetn)
		wd.txn_start |=> (pre_q == '0 && unit_q == '0 && wd.txn_busy))
		else $error("Watchdog count not restarted on new transaction");
	AST_WDT_EXPIRE_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
		(tick && !wd.txn_start && !wd.txn_done && wd.timeout_units != '0 &&
			unit_q + 7'h01 < wd.timeout_units) |=> !wd.txn_abort)
		else $error("Watchdog aborted before programmed timeout");
endmodule

// [gpio_output_watchdog_config_test.sv]
// Self-checking bench for the pin, strap override and watchdog register group.
// Assumes the design carries its own assertions; the bench drives every port itself.
`timescale 1ns/1ps
module gpio_output_watchdog_config_test;
	import gpio_wdt_pkg::*;
	localparam int UNIT = 4;
	logic       mclk;
	logic       resetn;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic       strap_gate;
	logic       strap_sleep;
	logic       gate_sel;
	logic       sleep_sel;
	logic       start;
	logic       done;
	logic       abort;
	logic       busy;
	int         err_count;
	int         num_checks;

	gpio_output_watchdog_config #(.WDT_UNIT_CYCLES(UNIT)) dut_u (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pin_in(4'h0), .pin_out(pin_out), .pin_oe(pin_oe),
		.strap_output_gate_select(strap_gate), .strap_output_sleep_state_select(strap_sleep),
		.output_gate_select(gate_sel), .output_sleep_state_select(sleep_sel),
		.bidir_control_channel_start(start), .bidir_control_channel_done(done),
		.bidir_control_channel_abort(abort), .bidir_control_channel_busy(busy)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic read_expect(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		check8("rvalid", 8'h01, {7'h00, reg_rvalid});
		check8("rdata", exp, reg_rdata);
	endtask

	task automatic pulse(input bit is_start);
		@(posedge mclk);
		if (is_start) start <= 1'b1;
		else done <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		done  <= 1'b0;
	endtask

	// Edges after the edge that samples start until abort shows
	task automatic wait_abort(input int exp_n);
		int n;
		n = 0;
		while (abort !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 1000) begin
				err_count++;
				$display("ERROR abort wait expected %0d seen none", exp_n);
				complete_run();
			end
		end
		check8("abort_delay", exp_n[7:0], n[7:0]);
		check8("busy_at_abort", 8'h00, {7'h00, busy});
		cycles(1);
		check8("abort_width", 8'h00, {7'h00, abort});
	endtask

	// Count abort pulses over a quiet window
	task automatic no_abort(input int n);
		int hits;
		hits = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (abort !== 1'b0) hits++;
		end
		check8("abort_quiet", 8'h00, hits[7:0]);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		check8("pin_oe_rst", 8'h00, {4'h0, pin_oe});
		check8("pin_out_rst", 8'h00, {4'h0, pin_out});
		check8("wdt_rst", 8'h00, {6'h00, busy, abort});
		read_expect(PIN23_CFG_ADDR, 8'h33);
		read_expect(PIN01_CFG_ADDR, 8'h33);
		read_expect(STRAP_OVR_ADDR, 8'h20);
		read_expect(WDT_CTRL_ADDR, 8'hFE);
		read_expect(8'h21, 8'h00);
		check8("gate_strap", 8'h00, {7'h00, gate_sel});
		check8("sleep_strap", 8'h01, {7'h00, sleep_sel});
	endtask

	task automatic test_pins();
		logic [7:0] v [6];
		logic [7:0] a;
		logic [7:0] b;
		logic [3:0] oe;
		logic [3:0] dv;
		v = '{8'h90, 8'h09, 8'hB3, 8'h11, 8'h99, 8'hFF};
		for (int i = 0; i < 6; i++) begin
			a = v[i];
			b = v[(i + 1) % 6];
			reg_write(PIN01_CFG_ADDR, a);
			reg_write(PIN23_CFG_ADDR, b);
			oe = {b[0] & ~b[1], b[4] & ~b[5], a[0] & ~a[1], a[4] & ~a[5]};
			dv = {b[3], b[7], a[3], a[7]};
			cycles(1);
			check8("pin_oe", {4'h0, oe}, {4'h0, pin_oe});
			check8("pin_out", {4'h0, oe & dv}, {4'h0, pin_out});
			read_expect(PIN01_CFG_ADDR, a & 8'hBB);
			read_expect(PIN23_CFG_ADDR, b & 8'hBB);
		end
	endtask

	task automatic test_strap();
		@(posedge mclk);
		strap_gate <= 1'b1;
		cycles(3);
		check8("gate_follow", 8'h01, {7'h00, gate_sel});
		reg_write(STRAP_OVR_ADDR, 8'h80);
		strap_sleep <= 1'b0;
		cycles(3);
		check8("gate_ovr0", 8'h00, {7'h00, gate_sel});
		check8("sleep_ovr", 8'h01, {7'h00, sleep_sel});
		read_expect(STRAP_OVR_ADDR, 8'hA0);
		reg_write(STRAP_OVR_ADDR, 8'hDF);
		strap_gate <= 1'b0;
		cycles(3);
		check8("gate_ovr1", 8'h01, {7'h00, gate_sel});
		read_expect(STRAP_OVR_ADDR, 8'hE0);
		reg_write(STRAP_OVR_ADDR, 8'h40);
		cycles(3);
		check8("gate_back", 8'h00, {7'h00, gate_sel});
		check8("sleep_back", 8'h00, {7'h00, sleep_sel});
	endtask

	task automatic test_expiry(input logic [6:0] t);
		reg_write(WDT_CTRL_ADDR, {t, 1'b0});
		pulse(1'b1);
		#1;
		check8("busy_start", 8'h01, {7'h00, busy});
		wait_abort(int'(t) * UNIT);
	endtask

	task automatic test_done();
		reg_write(WDT_CTRL_ADDR, 8'h02);
		pulse(1'b1);
		cycles(2);
		pulse(1'b0);
		#1;
		check8("busy_done", 8'h00, {7'h00, busy});
		no_abort(3 * UNIT);
	endtask

	task automatic test_restart();
		reg_write(WDT_CTRL_ADDR, 8'h04);
		pulse(1'b1);
		cycles(UNIT);
		pulse(1'b1);
		wait_abort(2 * UNIT);
	endtask

	task automatic test_disable();
		reg_write(WDT_CTRL_ADDR, 8'h03);
		read_expect(WDT_CTRL_ADDR, 8'h03);
		pulse(1'b1);
		no_abort(4 * UNIT);
		check8("busy_dis", 8'h01, {7'h00, busy});
		pulse(1'b0);
		#1;
		check8("busy_dis_done", 8'h00, {7'h00, busy});
	endtask

	// ----------------------------------------------------------------
	// Clock, reset and main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		err_count   = 0;
		num_checks  = 0;
		resetn      = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		strap_gate  = 1'b0;
		strap_sleep = 1'b1;
		start       = 1'b0;
		done        = 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		cycles(2);
		test_reset();
		test_pins();
		test_strap();
		test_expiry(7'd1);
		test_expiry(7'd3);
		test_done();
		test_restart();
		test_disable();
		complete_run();
	end
endmodule
